// *** dv/spsh_master_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// External master on the parallel bus, one access per call
module spsh_master_model
(
    input  wire logic                 i_clk_sys,
    output logic                      o_cs_n,
    output logic                      o_rd_n,
    output logic                      o_wr_n,
    output logic                      o_ale,
    output logic                      o_a1,
    output spsh_pkg::spsh_byte_t      o_data,
    input  wire logic                 i_oe,
    input  wire spsh_pkg::spsh_byte_t i_rdata
);
    import spsh_pkg::*;
    // Bus idle at time zero
    initial
    begin
        {o_cs_n, o_rd_n, o_wr_n, o_ale, o_a1} = 5'h1c;
        o_data = 8'h00;
    end
    // Address phase, strobe held two edges, then release
    task automatic access(input logic wr, input logic sel, input spsh_byte_t d, output spsh_byte_t q);
        o_ale = 1'b1;
        o_data = {6'h00, sel, 1'b0};   // Select rides on bit 1
        o_a1 = ~sel;                   // Live pin disagrees on purpose
        @(posedge i_clk_sys);
        #1;
        o_ale = 1'b0;
        o_cs_n = 1'b0;
        o_rd_n = wr;
        o_wr_n = ~wr;
        o_data = wr ? d : ~o_data;
        @(posedge i_clk_sys);
        @(posedge i_clk_sys);
        q = i_oe ? i_rdata : ~i_rdata; // Taken while strobe held; undriven bus reads garbage
        #1;
        {o_cs_n, o_rd_n, o_wr_n} = 3'h7;
        o_data = ~o_data;              // Released bus never keeps old value
        repeat (2) @(posedge i_clk_sys);
        #1;
    endtask : access
endmodule : spsh_master_model
`default_nettype wire

// *** dv/test_slave_port_status_handshake.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spsh_defs.svh"
module test_slave_port_status_handshake;
    import spsh_pkg::*;
    logic       clk_sys, rstn, loc_wr, loc_rd, cs_n, rd_n, wr_n, ale, a1, attn, oe;
    logic [15:0] loc_addr;
    logic [2:0] pend_clr, irq_mask, pend, irq_req;
    spsh_byte_t loc_wdata, loc_rdata, ms_data, ms_rdata, q;
    int         n_mismatch = 0;
    int         checked = 0;

    spsh_top spsh_top_inst (.i_clk_sys(clk_sys), .i_rstn(rstn), .i_loc_addr(loc_addr), .i_loc_wr(loc_wr),
        .i_loc_rd(loc_rd), .i_loc_wdata(loc_wdata), .o_loc_rdata(loc_rdata), .i_pend_clr(pend_clr),
        .i_irq_mask(irq_mask), .o_pend(pend), .o_irq_req(irq_req), .i_ms_cs_n(cs_n), .i_ms_rd_n(rd_n),
        .i_ms_wr_n(wr_n), .i_ms_ale(ale), .i_ms_a1(a1), .i_ms_data(ms_data), .o_ms_data(ms_rdata),
        .o_ms_data_oe(oe), .o_master_attention_out(attn));
    spsh_master_model spsh_master_model_inst (.i_clk_sys(clk_sys), .o_cs_n(cs_n), .o_rd_n(rd_n),
        .o_wr_n(wr_n), .o_ale(ale), .o_a1(a1), .o_data(ms_data), .i_oe(oe), .i_rdata(ms_rdata));

    // 50 MHz clock
    initial
    begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Verdict in one place
    task automatic finish_test();
        if (n_mismatch == 0 && checked > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : finish_test
    // Compare and count
    task automatic check(input spsh_byte_t seen, input spsh_byte_t exp);
        checked++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // Local write; idle edge after so strobe never re-rises in one step
    task automatic lwrite(input logic [15:0] a, input spsh_byte_t d);
        loc_addr = a;
        loc_wdata = d;
        loc_wr = 1'b1;
        @(posedge clk_sys);
        #1;
        loc_wr = 1'b0;
        @(posedge clk_sys);
        #1;
    endtask : lwrite
    // Local read, data registered one cycle later
    task automatic lread(input logic [15:0] a, output spsh_byte_t d);
        loc_addr = a;
        loc_rd = 1'b1;
        @(posedge clk_sys);
        #1;
        loc_rd = 1'b0;
        d = loc_rdata;
        @(posedge clk_sys);
        #1;
    endtask : lread
    task automatic chk_loc(input logic [15:0] a, input spsh_byte_t exp);
        spsh_byte_t d;
        lread(a, d);
        check(d, exp);
    endtask : chk_loc
    // Let flag and attention updates land
    task automatic settle();
        repeat (2) @(posedge clk_sys);
        #1;
    endtask : settle
    // Hang guard, far beyond the roughly 120 cycles needed
    initial
    begin
        #100000;
        n_mismatch++;
        finish_test();
    end
    // Main sequence
    initial
    begin
        {rstn, loc_wr, loc_rd, pend_clr, loc_addr, loc_wdata} = '0;
        irq_mask = 3'h7;
        repeat (4) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        chk_loc(`SPSH_ADDR_STATUS, 8'h00);
        chk_loc(`SPSH_ADDR_CONTROL, 8'h00);
        lwrite(`SPSH_ADDR_CONTROL, 8'hef); // Reserved bits must read back zero
        chk_loc(`SPSH_ADDR_CONTROL, 8'h0f);
        lwrite(`SPSH_ADDR_OUT_DATA, 8'h96);
        lread(`SPSH_ADDR_IN_DATA, q);
        lread(`SPSH_ADDR_CMD, q);
        chk_loc(`SPSH_ADDR_STATUS, 8'h07);
        // Bit 7 bracket around a field update
        lwrite(`SPSH_ADDR_STATUS, 8'h00);
        lwrite(`SPSH_ADDR_STATUS, 8'h28);
        lwrite(`SPSH_ADDR_STATUS, 8'ha8);
        chk_loc(`SPSH_ADDR_STATUS, 8'haf);
        // Mask table: only obf mask, then none, then both
        lwrite(`SPSH_ADDR_CONTROL, 8'h0d);
        settle();
        check({7'h00, attn}, 8'h01);
        lwrite(`SPSH_ADDR_CONTROL, 8'h0c);
        settle();
        check({7'h00, attn}, 8'h00);
        lwrite(`SPSH_ADDR_CONTROL, 8'h0f);
        settle();
        check({7'h00, attn}, 8'h01);
        // Master command write, then status read twice
        spsh_master_model_inst.access(1'b1, 1'b1, 8'h5a, q);
        check({5'h00, pend}, 8'h01);
        check({5'h00, irq_req}, 8'h01);
        chk_loc(`SPSH_ADDR_STATUS, 8'hab);
        chk_loc(`SPSH_ADDR_CMD, 8'h5a);
        spsh_master_model_inst.access(1'b0, 1'b1, 8'h00, q);
        check(q, 8'haf);
        spsh_master_model_inst.access(1'b0, 1'b1, 8'h00, q);
        check(q, 8'haf);
        check({7'h00, oe}, 8'h00);
        // Demultiplexed select: live pin decides with latch bit clear
        lwrite(`SPSH_ADDR_CONTROL, 8'h0b);
        spsh_master_model_inst.access(1'b0, 1'b0, 8'h00, q);
        check(q, 8'haf);
        lwrite(`SPSH_ADDR_CONTROL, 8'h0f);
        // Data write and read with select low
        spsh_master_model_inst.access(1'b1, 1'b0, 8'h3c, q);
        check({5'h00, pend}, 8'h05);
        spsh_master_model_inst.access(1'b0, 1'b0, 8'h00, q);
        check(q, 8'h96);
        check({5'h00, pend}, 8'h07);
        check({5'h00, irq_req}, 8'h01);
        chk_loc(`SPSH_ADDR_STATUS, 8'hac);
        check({7'h00, attn}, 8'h00);
        chk_loc(`SPSH_ADDR_IN_DATA, 8'h3c);
        settle();
        check({7'h00, attn}, 8'h01);
        // Disable clears flags and ignores the master
        pend_clr = 3'h7;
        @(posedge clk_sys);
        #1;
        pend_clr = 3'h0;
        lwrite(`SPSH_ADDR_CONTROL, 8'h07);
        chk_loc(`SPSH_ADDR_STATUS, 8'ha8);
        spsh_master_model_inst.access(1'b1, 1'b1, 8'h11, q);
        check({5'h00, pend}, 8'h00);
        // Shared mode direction bit and requests
        lwrite(`SPSH_ADDR_CONTROL, 8'h1b);
        spsh_master_model_inst.access(1'b0, 1'b0, 8'h00, q);
        chk_loc(`SPSH_ADDR_STATUS, 8'ha8);
        lwrite(`SPSH_ADDR_STATUS, 8'h00);
        chk_loc(`SPSH_ADDR_STATUS, 8'h80);
        spsh_master_model_inst.access(1'b1, 1'b0, 8'h44, q);
        chk_loc(`SPSH_ADDR_STATUS, 8'h00);
        check({5'h00, irq_req}, 8'h06);
        check({7'h00, attn}, 8'h00);
        lread(`SPSH_ADDR_IN_DATA, q);
        settle();
        check({7'h00, attn}, 8'h01);
        chk_loc(16'h1ff0, 8'h00);
        finish_test();
    end
endmodule : test_slave_port_status_handshake
`default_nettype wire

// *** hw/spsh_defs.svh ***
`ifndef SPSH_DEFS_SVH
`define SPSH_DEFS_SVH
// Local register addresses
`define SPSH_ADDR_STATUS   16'h1ff8
`define SPSH_ADDR_CONTROL  16'h1ffb
`define SPSH_ADDR_CMD      16'h1ffa
`define SPSH_ADDR_OUT_DATA 16'h1ffc
`define SPSH_ADDR_IN_DATA  16'h1ffe
// Control register bit positions
`define SPSH_CON_OBF_MASK  0
`define SPSH_CON_IBE_MASK  1
`define SPSH_CON_LATCH     2
`define SPSH_CON_ENABLE    3
`define SPSH_CON_SHARED    4
`define SPSH_CON_WMASK     8'h1f
// Status register bit positions
`define SPSH_ST_OBF        0
`define SPSH_ST_IBE        1
`define SPSH_ST_CBE        2
`define SPSH_ST_SF_LO      3
`define SPSH_ST_SF_HI      7
// Pending bit indices inside the request group
`define SPSH_PEND_CBF      0
`define SPSH_PEND_OBE      1
`define SPSH_PEND_IBF      2
`define SPSH_PEND_N        3
// Reset values
`define SPSH_BYTE_RST      8'h00
`define SPSH_SF_RST        5'h00
`define SPSH_PEND_RST      3'h0
`endif

// *** hw/spsh_master_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spsh_defs.svh"
module spsh_master_if
    import spsh_pkg::*;
(
    input  wire logic             i_clk_sys,
    input  wire logic             i_rstn,
    input  wire logic             i_enable,
    input  wire logic             i_latch_select,
    input  wire logic             i_ms_cs_n,
    input  wire logic             i_ms_rd_n,
    input  wire logic             i_ms_wr_n,
    input  wire logic             i_ms_ale,
    input  wire logic             i_ms_a1,
    input  wire spsh_pkg::spsh_byte_t i_ms_data,
    output logic                  o_rd_pulse,
    output logic                  o_wr_pulse,
    output logic                  o_active,
    output logic                  o_sel,
    output spsh_pkg::spsh_byte_t  o_addr_byte
);
    spsh_ms_state_t state_r;       // Access sequencer
    logic           ad1_latch_r;   // Select bit caught on address phase

    // Address phase latch; multiplexed bus carries select on bit 1
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            ad1_latch_r <= 1'b0;
            o_addr_byte <= `SPSH_BYTE_RST;
        end
        else if (i_ms_ale)
        begin
            ad1_latch_r <= i_ms_data[1];
            o_addr_byte <= i_ms_data;
        end
    end

    // Select source: latched line or demultiplexed address pin
    assign o_sel = i_latch_select ? ad1_latch_r : i_ms_a1;

    // One access per strobe; held until the strobe is released
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            state_r <= SPSH_IDLE;
        else
        begin
            case (state_r)
                SPSH_IDLE:
                begin
                    if (i_enable && !i_ms_cs_n && !i_ms_rd_n)
                        state_r <= SPSH_RD;
                    else if (i_enable && !i_ms_cs_n && !i_ms_wr_n)
                        state_r <= SPSH_WR;
                end
                SPSH_RD:
                    if (i_ms_cs_n || i_ms_rd_n)
                        state_r <= SPSH_IDLE;
                SPSH_WR:
                    if (i_ms_cs_n || i_ms_wr_n)
                        state_r <= SPSH_IDLE;
                default:
                    state_r <= SPSH_IDLE;
            endcase
        end
    end

    // Pulses on the first cycle of a strobe; read wins a clash
    assign o_rd_pulse = (state_r == SPSH_IDLE) && i_enable && !i_ms_cs_n && !i_ms_rd_n;
    assign o_wr_pulse = (state_r == SPSH_IDLE) && i_enable && !i_ms_cs_n && i_ms_rd_n && !i_ms_wr_n;
    assign o_active   = (state_r == SPSH_RD);
endmodule : spsh_master_if
`default_nettype wire

// *** hw/spsh_pend.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "spsh_defs.svh"
module spsh_pend
(
    input  wire logic                    i_clk_sys,
    input  wire logic                    i_rstn,
    input  wire logic [`SPSH_PEND_N-1:0] i_set,
    input  wire logic [`SPSH_PEND_N-1:0] i_clr,
    input  wire logic [`SPSH_PEND_N-1:0] i_mask,
    input  wire logic [`SPSH_PEND_N-1:0] i_mode_ok,
    output logic      [`SPSH_PEND_N-1:0] o_pend,
    output logic      [`SPSH_PEND_N-1:0] o_req
);
    // One sticky bit per request; a set beats a same-cycle clear
    for (genvar g = 0; g < `SPSH_PEND_N; g++)
    begin : g_pend
        always_ff @(posedge i_clk_sys or negedge i_rstn)
        begin
            if (!i_rstn)
            begin
                o_pend[g] <= 1'b0;
                o_req[g]  <= 1'b0;
            end
            else
            begin
                o_pend[g] <= i_set[g] | (o_pend[g] & ~i_clr[g]);
                // Request only in its own mode and with its mask bit
                o_req[g]  <= (i_set[g] | (o_pend[g] & ~i_clr[g])) & i_mask[g] & i_mode_ok[g];
            end
        end
    end

    property p_req_gate;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        ##1 (o_req != 3'h0) |-> ((o_req & ~o_pend) == 3'h0) && ((o_req & ~$past(i_mask)) == 3'h0);
    endproperty
    a_req_gate: assert property (p_req_gate) else $error("request without pending or mask");
endmodule : spsh_pend
`default_nettype wire

// *** hw/spsh_pkg.sv ***
package spsh_pkg;
    // Master access sequencer states, one-hot
    typedef enum logic [2:0]
    {
        SPSH_IDLE = 3'b001,
        SPSH_RD   = 3'b010,
        SPSH_WR   = 3'b100
    } spsh_ms_state_t;

    typedef logic [7:0] spsh_byte_t;

    // Local address match, used by every register decode
    function automatic logic spsh_hit(input logic [15:0] a, input logic [15:0] b);
        spsh_hit = (a == b);
    endfunction : spsh_hit
endpackage : spsh_pkg

// *** hw/spsh_top.sv ***
// Function
// - Two masks gate flags onto attention output in standard mode
// - Three master requests, each mask enabled
// - Local reads all status, writes 7:3 (6:3 in shared mode)
// - Master status writes land in command
// - Shared mode bit 7 shows last direction
// - Standard mode bit 7 is status field
// - Command empty flag and full request
// - Input empty flag and full request
// - Output full flag and empty request
// - Software brackets status update with bit 7
// - Disable clears the three buffer flags
// - Latch bit picks register select source
// - Shared mode local data access forces attention high
// - Control bit 4 selects shared mode
`timescale 1ns/1ps
`default_nettype none
`include "spsh_defs.svh"
module spsh_top
    import spsh_pkg::*;
#(
    parameter logic HAS_SHARED = 1'b1          // Variant supports shared memory mode
)
(
    input  wire logic                  i_clk_sys,
    input  wire logic                  i_rstn,
    // Local CPU register port
    input  wire logic [15:0]           i_loc_addr,
    input  wire logic                  i_loc_wr,
    input  wire logic                  i_loc_rd,
    input  wire spsh_pkg::spsh_byte_t  i_loc_wdata,
    output spsh_pkg::spsh_byte_t       o_loc_rdata,
    // Interrupt controller side
    input  wire logic [2:0]            i_pend_clr,
    input  wire logic [2:0]            i_irq_mask,
    output logic [2:0]                 o_pend,
    output logic [2:0]                 o_irq_req,
    // Master bus pins
    input  wire logic                  i_ms_cs_n,
    input  wire logic                  i_ms_rd_n,
    input  wire logic                  i_ms_wr_n,
    input  wire logic                  i_ms_ale,
    input  wire logic                  i_ms_a1,
    input  wire spsh_pkg::spsh_byte_t  i_ms_data,
    output spsh_pkg::spsh_byte_t       o_ms_data,
    output logic                       o_ms_data_oe,
    output logic                       o_master_attention_out
);
    import spsh_pkg::*;

    spsh_byte_t control_r;                 // slave_port_control
    spsh_byte_t command_r;                 // command_register
    spsh_byte_t in_data_r;                 // input_data_register
    spsh_byte_t out_data_r;                // output_data_register
    logic [4:0] sf_r;                      // General status field
    logic       shared_access_direction_r; // 1 read, 0 write
    logic       cbe_r;                     // command_buffer_empty_flag
    logic       ibe_r;                     // input_buffer_empty_flag
    logic       obf_r;                     // output_buffer_full_flag
    logic       cbe_nxt;
    logic       ibe_nxt;
    logic       obf_nxt;
    logic       ms_rd;                     // Master read, first cycle
    logic       ms_wr;                     // Master write, first cycle
    logic       ms_active;                 // Master read strobe held
    logic       ms_sel;                    // Register select (status side)
    spsh_byte_t ms_addr;                   // Address byte of the access
    spsh_byte_t status_w;                  // Assembled status view
    logic [2:0] pend_set;
    logic [2:0] mode_ok;

    // Control field aliases
    wire logic port_enable_bit      = control_r[`SPSH_CON_ENABLE];
    wire logic latch_select         = control_r[`SPSH_CON_LATCH];
    wire logic in_empty_attn_mask   = control_r[`SPSH_CON_IBE_MASK];
    wire logic out_full_attn_mask   = control_r[`SPSH_CON_OBF_MASK];
    wire logic shared_memory_enable = HAS_SHARED & control_r[`SPSH_CON_SHARED];

    // Local strobes per register
    wire logic lw_status = i_loc_wr && spsh_hit(i_loc_addr, `SPSH_ADDR_STATUS);
    wire logic lw_con    = i_loc_wr && spsh_hit(i_loc_addr, `SPSH_ADDR_CONTROL);
    wire logic lw_cmd    = i_loc_wr && spsh_hit(i_loc_addr, `SPSH_ADDR_CMD);
    wire logic lw_in     = i_loc_wr && spsh_hit(i_loc_addr, `SPSH_ADDR_IN_DATA);
    wire logic lw_out    = i_loc_wr && spsh_hit(i_loc_addr, `SPSH_ADDR_OUT_DATA);
    wire logic lr_cmd    = i_loc_rd && spsh_hit(i_loc_addr, `SPSH_ADDR_CMD);
    wire logic lr_in     = i_loc_rd && spsh_hit(i_loc_addr, `SPSH_ADDR_IN_DATA);

    // Master events by mode; select high means command/status side
    wire logic std_mode   = !shared_memory_enable;
    wire logic m_wr_cmd   = ms_wr && std_mode && ms_sel;
    wire logic m_wr_data  = ms_wr && (shared_memory_enable || !ms_sel);
    wire logic m_rd_data  = ms_rd && (shared_memory_enable || !ms_sel);
    wire logic m_rd_stat  = ms_rd && std_mode && ms_sel;

    spsh_master_if u_master_if
    (
        .i_clk_sys      (i_clk_sys),
        .i_rstn         (i_rstn),
        .i_enable       (port_enable_bit),
        .i_latch_select (latch_select),
        .i_ms_cs_n      (i_ms_cs_n),
        .i_ms_rd_n      (i_ms_rd_n),
        .i_ms_wr_n      (i_ms_wr_n),
        .i_ms_ale       (i_ms_ale),
        .i_ms_a1        (i_ms_a1),
        .i_ms_data      (i_ms_data),
        .o_rd_pulse     (ms_rd),
        .o_wr_pulse     (ms_wr),
        .o_active       (ms_active),
        .o_sel          (ms_sel),
        .o_addr_byte    (ms_addr)
    );

    // Bit 7 shows direction in shared mode, else the field top bit
    always_comb
    begin
        status_w                          = `SPSH_BYTE_RST;
        status_w[`SPSH_ST_SF_HI:`SPSH_ST_SF_LO] = sf_r;
        if (shared_memory_enable)
            status_w[`SPSH_ST_SF_HI]      = shared_access_direction_r;
        status_w[`SPSH_ST_CBE]            = cbe_r;
        status_w[`SPSH_ST_IBE]            = ibe_r;
        status_w[`SPSH_ST_OBF]            = obf_r;
    end

    // Flag next values; local set beats master clear, disable beats all
    always_comb
    begin
        cbe_nxt = lr_cmd | (cbe_r & ~m_wr_cmd);
        ibe_nxt = lr_in  | (ibe_r & ~m_wr_data);
        obf_nxt = lw_out | (obf_r & ~m_rd_data);
        if (!port_enable_bit)
        begin
            cbe_nxt = 1'b0;
            ibe_nxt = 1'b0;
            obf_nxt = 1'b0;
        end
    end

    // Buffer flags
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            cbe_r <= 1'b0;
            ibe_r <= 1'b0;
            obf_r <= 1'b0;
        end
        else
        begin
            cbe_r <= cbe_nxt;
            ibe_r <= ibe_nxt;
            obf_r <= obf_nxt;
        end
    end

    // Control register; reserved bits stay zero
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            control_r <= `SPSH_BYTE_RST;
        else if (lw_con)
            control_r <= i_loc_wdata & `SPSH_CON_WMASK;
    end

    // Status field: only local writes; bit 7 frozen in shared mode
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            sf_r <= `SPSH_SF_RST;
        else if (lw_status)
        begin
            // Each bit written as given in standard mode, so bit 7 can bracket an update
            sf_r[3:0] <= i_loc_wdata[`SPSH_ST_SF_HI-1:`SPSH_ST_SF_LO];
            if (!shared_memory_enable)
                sf_r[4] <= i_loc_wdata[`SPSH_ST_SF_HI];
        end
    end

    // Direction of the last shared access; not writable by software
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            shared_access_direction_r <= 1'b0;
        else if (shared_memory_enable && ms_rd)
            shared_access_direction_r <= 1'b1;
        else if (shared_memory_enable && ms_wr)
            shared_access_direction_r <= 1'b0;
    end

    // Command register; shared mode keeps the latched address there
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            command_r <= `SPSH_BYTE_RST;
        else if (m_wr_cmd)
            command_r <= i_ms_data;
        else if (shared_memory_enable && (ms_rd || ms_wr))
            command_r <= ms_addr;
        else if (lw_cmd)
            command_r <= i_loc_wdata;
    end

    // Data buffers; master write beats a same-cycle local write
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            in_data_r  <= `SPSH_BYTE_RST;
            out_data_r <= `SPSH_BYTE_RST;
        end
        else
        begin
            if (m_wr_data)
                in_data_r <= i_ms_data;
            else if (lw_in)
                in_data_r <= i_loc_wdata;
            if (lw_out)
                out_data_r <= i_loc_wdata;
        end
    end

    // Pending bits and requests; command request only in standard mode
    assign pend_set[`SPSH_PEND_CBF] = m_wr_cmd;
    assign pend_set[`SPSH_PEND_OBE] = m_rd_data;
    assign pend_set[`SPSH_PEND_IBF] = m_wr_data;
    assign mode_ok = {shared_memory_enable, shared_memory_enable, std_mode};

    spsh_pend u_pend
    (
        .i_clk_sys (i_clk_sys),
        .i_rstn    (i_rstn),
        .i_set     (pend_set),
        .i_clr     (i_pend_clr),
        .i_mask    (i_irq_mask),
        .i_mode_ok (mode_ok),
        .o_pend    (o_pend),
        .o_req     (o_irq_req)
    );

    // Local read data, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_loc_rdata <= `SPSH_BYTE_RST;
        else if (i_loc_rd)
        begin
            if (spsh_hit(i_loc_addr, `SPSH_ADDR_STATUS))
                o_loc_rdata <= status_w;
            else if (spsh_hit(i_loc_addr, `SPSH_ADDR_CONTROL))
                o_loc_rdata <= control_r;
            else if (lr_cmd)
                o_loc_rdata <= command_r;
            else if (lr_in)
                o_loc_rdata <= in_data_r;
            else if (spsh_hit(i_loc_addr, `SPSH_ADDR_OUT_DATA))
                o_loc_rdata <= out_data_r;
            else
                o_loc_rdata <= `SPSH_BYTE_RST;
        end
    end

    // Master read data: captured at strobe start so it cannot tear
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_ms_data    <= `SPSH_BYTE_RST;
            o_ms_data_oe <= 1'b0;
        end
        else
        begin
            if (m_rd_stat)
                o_ms_data <= status_w;
            else if (m_rd_data)
                o_ms_data <= out_data_r;
            o_ms_data_oe <= ms_rd || (ms_active && !i_ms_cs_n && !i_ms_rd_n);
        end
    end

    // Attention: masked flags in standard mode, handshake in shared mode
    always_ff @(posedge i_clk_sys or negedge i_rstn)
    begin
        if (!i_rstn)
            o_master_attention_out <= 1'b0;
        else if (std_mode)
            o_master_attention_out <= (ibe_nxt & in_empty_attn_mask) | (obf_nxt & out_full_attn_mask);
        else if (lr_in || lw_out)
            o_master_attention_out <= 1'b1;
        else if (ms_rd || ms_wr)
            o_master_attention_out <= 1'b0;
    end

    property p_attn_std;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        std_mode |=> o_master_attention_out ==
            ((ibe_r & $past(in_empty_attn_mask)) | (obf_r & $past(out_full_attn_mask)));
    endproperty
    a_attn_std: assert property (p_attn_std) else $error("attention not masked flag OR");

    property p_attn_shared;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (shared_memory_enable && (lr_in || lw_out)) |=> o_master_attention_out;
    endproperty
    a_attn_shared: assert property (p_attn_shared) else $error("local data access left attention low");

    property p_cbe_cycle;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (port_enable_bit && m_wr_cmd && !lr_cmd) |=> !cbe_r && o_pend[`SPSH_PEND_CBF];
    endproperty
    a_cbe_cycle: assert property (p_cbe_cycle) else $error("command write did not clear empty flag");

    property p_ibe_set;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (port_enable_bit && lr_in) |=> ibe_r ##1 (ibe_r || $past(m_wr_data) || !$past(port_enable_bit));
    endproperty
    a_ibe_set: assert property (p_ibe_set) else $error("input empty flag not set by local read");

    property p_obf_clr;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (m_rd_data && !lw_out) |=> !obf_r && o_pend[`SPSH_PEND_OBE];
    endproperty
    a_obf_clr: assert property (p_obf_clr) else $error("master read did not clear output full");

    property p_disable;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        !port_enable_bit |=> !cbe_r && !ibe_r && !obf_r;
    endproperty
    a_disable: assert property (p_disable) else $error("flags survive port disable");

    property p_master_no_status;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (m_wr_cmd && !lw_status) |=> (sf_r == $past(sf_r)) && (command_r == $past(i_ms_data));
    endproperty
    a_master_no_status: assert property (p_master_no_status) else $error("master write reached status");

    property p_dir_ro;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (shared_memory_enable && lw_status && !ms_rd && !ms_wr) |=>
            shared_access_direction_r == $past(shared_access_direction_r);
    endproperty
    a_dir_ro: assert property (p_dir_ro) else $error("direction bit changed by write");

    property p_dir_read;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (shared_memory_enable && ms_rd) |=> status_w[`SPSH_ST_SF_HI] || !shared_memory_enable;
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("bit 7 not set after shared read");

    property p_field_write;
        @(posedge i_clk_sys) disable iff (!i_rstn)
        (std_mode && lw_status) |=> sf_r == $past(i_loc_wdata[7:3]);
    endproperty
    a_field_write: assert property (p_field_write) else $error("status field write lost");
endmodule : spsh_top
`default_nettype wire
